// [ascwd_top.sv]
// Purpose: Communications-loss watchdog gating auto-scan on five ports.
// Assumes: Classic Wishbone slave, one aligned 32-bit word per register.
// Notes: Answers every access with ack one cycle after the request is seen.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ascwd_top
  import ascwd_pkg::*;
#(
  parameter int TICK_CYCLES = ASCWD_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [17:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Reply results from the port engines
  input wire ascwd_reply_t reply_i,
  // Scan engine controls
  output logic [ASCWD_NPORTS-1:0] scan_run_o,
  output logic [ASCWD_NPORTS-1:0] poll_o,
  output logic expired_o
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] countdown;
  logic [15:0] port_mask;
  logic [15:0] interval;
  logic [ASCWD_NENTRIES-1:0] entry_en;
  logic tick;
  logic [ASCWD_NENTRIES-1:0] status [ASCWD_NPORTS];
  logic [ASCWD_NPORTS-1:0] poll;
  logic [ASCWD_NPORTS-1:0] next_run;
  ascwd_wb_req_t req;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i[17:2], dat: dat_i};
  wire logic access = req.cyc && req.stb && !ack_o;
  wire logic wr = access && req.we;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    return a == idx;
  endfunction

  // Merges a 16-bit write under byte enables.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ascwd_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Countdown: a bus write wins over the tick, so a reload is never eaten.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      countdown <= ASCWD_COUNTDOWN_RST;
    end else if (wr && hit(req.adr, ASCWD_IDX_COUNTDOWN)) begin
      countdown <= merge16(countdown, req.dat, req.sel);
    end else if (tick && countdown != 16'h0) begin
      countdown <= countdown - 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_mask <= ASCWD_PORT_MASK_RST;
      interval <= ASCWD_INTERVAL_RST;
      entry_en <= '0;
    end else if (wr) begin
      if (hit(req.adr, ASCWD_IDX_PORT_MASK)) begin
        port_mask <= merge16(port_mask, req.dat, req.sel);
      end
      if (hit(req.adr, ASCWD_IDX_INTERVAL)) begin
        interval <= merge16(interval, req.dat, req.sel);
      end
      for (int w = 0; w < ASCWD_STAT_WORDS; w++) begin
        if (hit(req.adr, ASCWD_IDX_ENTRY_EN + 16'(w))) begin
          entry_en[w*ASCWD_STAT_BITS +: ASCWD_STAT_BITS] <=
            merge16(entry_en[w*ASCWD_STAT_BITS +: ASCWD_STAT_BITS], req.dat, req.sel);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port p runs unless its mask bit is set and the countdown is zero.
  always_comb begin
    for (int p = 0; p < ASCWD_NPORTS; p++) begin
      next_run[p] = !(port_mask[p] && countdown == 16'h0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_run_o <= '0;
      expired_o <= 1'b0;
    end else begin
      scan_run_o <= next_run;
      expired_o <= (countdown == 16'h0);
    end
  end

  for (genvar g = 0; g < ASCWD_NPORTS; g++) begin : g_port
    ascwd_scan_port #(
      .NENTRIES(ASCWD_NENTRIES)
    ) u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .run_i(scan_run_o[g]),
      .interval_i(interval),
      .entry_en_i(entry_en),
      .ok_i(reply_i.ok[g]),
      .err_i(reply_i.err[g]),
      .entry_i(reply_i.entry),
      .poll_o(poll[g]),
      .status_o(status[g])
    );
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      poll_o <= '0;
    end else begin
      poll_o <= poll;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero and still acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= access;
      dat_o <= 32'h0;
      if (access && !req.we) begin
        if (hit(req.adr, ASCWD_IDX_RUNNING)) begin
          dat_o <= {27'h0, scan_run_o};
        end
        for (int w = 0; w < ASCWD_STAT_WORDS; w++) begin
          if (hit(req.adr, ASCWD_IDX_ENTRY_EN + 16'(w))) begin
            dat_o <= {16'h0, entry_en[w*ASCWD_STAT_BITS +: ASCWD_STAT_BITS]};
          end
        end
        // Status words: port p, word w at STATUS0 + 3*p + w.
        for (int p = 0; p < ASCWD_NPORTS; p++) begin
          for (int w = 0; w < ASCWD_STAT_WORDS; w++) begin
            if (hit(req.adr, ASCWD_IDX_STATUS0 + 16'(p * ASCWD_STAT_WORDS + w))) begin
              dat_o <= {16'h0, status[p][w*ASCWD_STAT_BITS +: ASCWD_STAT_BITS]};
            end
          end
        end
        // The status range overlaps RUNNING, countdown and port mask; countdown, port mask and interval are decoded last and win, but status overrides RUNNING.
        if (hit(req.adr, ASCWD_IDX_COUNTDOWN)) begin
          dat_o <= {16'h0, countdown};
        end else if (hit(req.adr, ASCWD_IDX_PORT_MASK)) begin
          dat_o <= {16'h0, port_mask};
        end else if (hit(req.adr, ASCWD_IDX_INTERVAL)) begin
          dat_o <= {16'h0, interval};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_reload;
    wr && hit(req.adr, ASCWD_IDX_COUNTDOWN) && req.sel[1:0] == 2'b11;
  endsequence

  AST_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reload |=> countdown == $past(req.dat[15:0])) else $error("reload lost");
  AST_DECREMENT: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && countdown != 16'h0 && !wr |=> countdown == $past(countdown) - 16'h1)
    else $error("countdown did not step");
  AST_HOLD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    countdown == 16'h0 && !wr |=> countdown == 16'h0) else $error("zero not held");
  AST_RESET_ZERO: assert property (@(posedge clk_i)
    rst_i |=> countdown == 16'h0) else $error("reset left countdown set");
  AST_UNMASKED_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_mask[0] |=> scan_run_o[0]) else $error("unmasked port stopped");
  AST_MASKED_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    port_mask[4] && countdown == 16'h0 |=> !scan_run_o[4])
    else $error("masked port kept running");
  AST_EXPIRE_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
    port_mask[1] && countdown == 16'h0 |=> ##1 status[1] == '0)
    else $error("status not cleared");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held too long");
  AST_MASK_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    countdown != 16'h0 |=> scan_run_o == '1) else $error("port stopped early");
endmodule
`default_nettype wire

// [ascwd_pkg.sv]
// Purpose: Shared constants and types for the auto-scan communications watchdog.
// Assumes: 250 MHz system clock, classic Wishbone register access.
// Notes: Registers are 16 bits wide, one per 32-bit word.
package ascwd_pkg;
  localparam int ASCWD_NPORTS = 5;
  localparam int ASCWD_NENTRIES = 48;
  localparam int ASCWD_STAT_BITS = 16;
  localparam int ASCWD_STAT_WORDS = 3;
  // Register word indices; byte address is four times the index.
  localparam logic [15:0] ASCWD_IDX_COUNTDOWN = 16'h1ffd;
  localparam logic [15:0] ASCWD_IDX_PORT_MASK = 16'h1ffe;
  localparam logic [15:0] ASCWD_IDX_INTERVAL = 16'h1ff0;
  localparam logic [15:0] ASCWD_IDX_ENTRY_EN = 16'h1ff1;
  localparam logic [15:0] ASCWD_IDX_STATUS0 = 16'h1ff4;
  localparam logic [15:0] ASCWD_IDX_RUNNING = 16'h1ff8;
  localparam logic [15:0] ASCWD_COUNTDOWN_RST = 16'h0000;
  localparam logic [15:0] ASCWD_PORT_MASK_RST = 16'h0000;
  localparam logic [15:0] ASCWD_INTERVAL_RST = 16'h0000;
  localparam int ASCWD_CLK_HZ = 250000000;
  localparam int ASCWD_TICK_MS = 10;
  localparam int ASCWD_TICK_CYCLES = ASCWD_CLK_HZ / 1000 * ASCWD_TICK_MS;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } ascwd_wb_req_t;
  typedef struct packed {
    logic [ASCWD_NPORTS-1:0] ok;
    logic [ASCWD_NPORTS-1:0] err;
    logic [5:0] entry;
  } ascwd_reply_t;
endpackage

// [ascwd_tick.sv]
// Purpose: Free-running 10 ms tick generator.
// Assumes: Synchronous active-high reset.
// Notes: Period is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`default_nettype none
module ascwd_tick #(
  parameter int TICK_CYCLES = 2500000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Tick out
  output logic tick_o
);
  logic [31:0] cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt == 32'(TICK_CYCLES - 1)) begin
      cnt <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [ascwd_scan_port.sv]
// Purpose: Per-port scan pacing and per-entry status bits.
// Assumes: Reply results arrive as single-cycle pulses from the port engine.
// Notes: A stopped port clears every status bit and issues no polls.
`timescale 1ns/1ps
`default_nettype none
module ascwd_scan_port
  import ascwd_pkg::*;
#(
  parameter int NENTRIES = 48
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [15:0] interval_i,
  input wire logic [NENTRIES-1:0] entry_en_i,
  // Reply results
  input wire logic ok_i,
  input wire logic err_i,
  input wire logic [5:0] entry_i,
  // Outputs
  output logic poll_o,
  output logic [NENTRIES-1:0] status_o
);
  logic [15:0] gap;
  wire logic active = run_i && (interval_i != 16'h0);
  // Polls are spaced by the interval in ticks; a zero interval stops polling but not the status bits.
  always_ff @(posedge clk_i) begin
    if (rst_i || !active) begin
      gap <= 16'h0;
      poll_o <= 1'b0;
    end else if (tick_i) begin
      if (gap <= 16'h1) begin
        gap <= interval_i;
        poll_o <= 1'b1;
      end else begin
        gap <= gap - 16'h1;
        poll_o <= 1'b0;
      end
    end else begin
      poll_o <= 1'b0;
    end
  end
  // A success sets the entry's bit; error or disable clears it.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      status_o <= '0;
    end else begin
      for (int i = 0; i < NENTRIES; i++) begin
        if (!entry_en_i[i]) begin
          status_o[i] <= 1'b0;
        end else if (ok_i && entry_i == 6'(i)) begin
          status_o[i] <= 1'b1;
        end else if (err_i && entry_i == 6'(i)) begin
          status_o[i] <= 1'b0;
        end
      end
    end
  end
  AST_STOP_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_i |=> status_o == '0 && !poll_o) else $error("stopped port kept status");
  AST_ZERO_INTERVAL: assert property (@(posedge clk_i) disable iff (rst_i)
    interval_i == 16'h0 |=> !poll_o) else $error("poll with zero interval");
endmodule
`default_nettype wire

// [ascwd_host_model.sv]
// Purpose: Host master model that reloads the watchdog over classic Wishbone.
// Assumes: Only the bench timeout ends a wait for a missing ack.
// Notes: Released lines show inverted data, so stale values cannot pass.
`timescale 1ns/1ps
`default_nettype none
module ascwd_host_model
  import ascwd_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] sel_o,
  output logic [17:0] adr_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  initial begin
    {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
  end
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o} <= {2'b11, w, 4'hf};
    adr_o <= a;
    dat_o <= d;
    ok = 1'b0;
    q = '0;
    while (!ok) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        q = dat_i;
      end
    end
    {cyc_o, stb_o} <= 2'b00;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
  // Reloads well inside the timeout, so scanning never lapses.
  task automatic keep_alive(input logic [15:0] v, input int n);
    logic [31:0] q;
    logic ok;
    repeat (n) begin
      xfer(1'b1, {ASCWD_IDX_COUNTDOWN, 2'b00}, {16'h0, v}, q, ok);
      repeat (20) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [ascwd_top_test.sv]
// Purpose: Self-checking bench for the auto-scan watchdog.
// Assumes: Tick shortened to 20 cycles.
// Notes: Expiry instants are checked with one tick of slack for phase.
`timescale 1ns/1ps
`default_nettype none
module ascwd_top_test
  import ascwd_pkg::*;
;
  localparam int TCK = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, expired, ok;
  logic [3:0] sel;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [ASCWD_NPORTS-1:0] run, poll;
  logic [15:0] mask, cnt;
  ascwd_reply_t reply = '0;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int e, c;
  always #2 clk_i = ~clk_i;
  ascwd_top #(.TICK_CYCLES(TCK)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .reply_i(reply), .scan_run_o(run), .poll_o(poll), .expired_o(expired));
  ascwd_host_model host_u (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .sel_o(sel), .adr_o(adr), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] exp_run(input logic [15:0] m, input logic dead);
    return {27'h0, dead ? ~m[4:0] : 5'h1f};
  endfunction
  task automatic acc(input logic w, input logic [15:0] i, input logic [15:0] v);
    host_u.xfer(w, {i, 2'b00}, {16'h0, v}, rd, ok);
    check("ack", {31'h0, ok}, 32'h1);
  endtask
  task automatic pulse(input logic [4:0] okp, input logic [4:0] errp);
    @(posedge clk_i);
    reply <= '{ok: okp, err: errp, entry: 6'(e)};
    @(posedge clk_i);
    reply <= '0;
  endtask
  task automatic polls(input int n);
    c = 0;
    repeat (n) begin
      @(posedge clk_i);
      c += (poll[1] === 1'b1);
    end
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    e = $urandom(32'h6bf9);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, ASCWD_IDX_COUNTDOWN, 0);
    check("count", rd, 32'h0);
    acc(1, 16'h0100, 16'hbeef);
    acc(0, 16'h0100, 0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      mask = (i == 0) ? 16'hffe0 : 16'($urandom);
      acc(1, ASCWD_IDX_PORT_MASK, mask);
      acc(0, ASCWD_IDX_PORT_MASK, 0);
      check("mask", rd, {16'h0, mask});
      check("run", {27'h0, run}, exp_run(mask, 1'b1));
    end
    mask = 16'h0001;
    acc(1, ASCWD_IDX_PORT_MASK, mask);
    acc(1, ASCWD_IDX_INTERVAL, 16'h0002);
    acc(1, ASCWD_IDX_ENTRY_EN, 16'hffff);
    acc(1, ASCWD_IDX_COUNTDOWN, 16'd60);
    repeat (2) @(posedge clk_i);
    check("revived", {27'h0, run}, 32'h1f);
    e = $urandom % 16;
    pulse(5'h03, 5'h00);
    acc(0, ASCWD_IDX_STATUS0, 0);
    check("st0", rd, 32'h1 << e);
    pulse(5'h00, 5'h02);
    acc(0, ASCWD_IDX_STATUS0 + 16'd3, 0);
    check("st1 err", rd, 32'h0);
    pulse(5'h02, 5'h00);
    polls(200);
    check("polls", {31'h0, c >= 4 && c <= 6}, 32'h1);
    acc(1, ASCWD_IDX_INTERVAL, 16'h0000);
    repeat (2) @(posedge clk_i);
    polls(100);
    check("no poll", c, 0);
    host_u.keep_alive(16'd3, 8);
    check("alive", {31'h0, expired}, 32'h0);
    cnt = 16'(2 + $urandom % 8);
    acc(1, ASCWD_IDX_COUNTDOWN, cnt);
    repeat ((cnt - 1) * TCK - 3) @(posedge clk_i);
    check("early", {27'h0, run}, 32'h1f);
    // A backup host waits this long before taking over.
    repeat (30) @(posedge clk_i);
    check("expired", {31'h0, expired}, 32'h1);
    check("stopped", {27'h0, run}, exp_run(mask, 1'b1));
    acc(0, ASCWD_IDX_COUNTDOWN, 0);
    check("hold", rd, 32'h0);
    acc(0, ASCWD_IDX_STATUS0, 0);
    check("st0 cleared", rd, 32'h0);
    acc(0, ASCWD_IDX_STATUS0 + 16'd3, 0);
    check("st1 kept", rd, 32'h1 << e);
    acc(1, ASCWD_IDX_COUNTDOWN, 16'd50);
    acc(0, ASCWD_IDX_COUNTDOWN, 0);
    check("reload", {31'h0, rd[15:0] >= 16'd49 && rd[15:0] <= 16'd50}, 32'h1);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, ASCWD_IDX_COUNTDOWN, 0);
    check("reboot", rd, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
